// ---- src/bpj_judge.sv ----
// Button press duration judge: sequencer, interval channel, indicators, APB slave
//
// Function
// - Sequencer starts only on the event link logic output.
// - Button edge interrupt fires on the falling edge, feeding the event link.
// - Millisecond channel counts system clock, 16 bit, ticks every 1 ms.
// - System clock runs at 32 MHz, here an enable from the main clock.
// - Each wait step lasts 125 ms counted on the low-speed wait clock.
// - After each wait, sample the button pin and branch on it.
// - Button pin is input only; there is no direction control.
// - Wait count is zero at the start of every run.
// - Still pressed: count plus one; below threshold, wait again.
// - Finish step ends the run and returns to idle.
// - Two indicator outputs, both driven high after reset.
// - Millisecond ticks time how long the timer indicator stays lit.
// - Released on sample: short press, finish without end interrupt.
// - Count reaches threshold: long press, raise sequence end interrupt.
// - Activity indicator lit from start until the run completes.
`timescale 1ns/1ns
`default_nettype none

module bpj_judge #(
	parameter int unsigned WAIT_LS_CYC = bpj_pkg::WAIT_LS_CYC,
	parameter int unsigned TICK_SYS_CYC = bpj_pkg::TICK_SYS_CYC
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire bpj_pkg::bpj_apb_req_s apb_req_i,
	output bpj_pkg::bpj_apb_rsp_s apb_rsp_o,
	input wire logic button_input_pin_i,
	output logic activity_indicator_output_o,
	output logic timer_indicator_output_o,
	output logic sequence_end_interrupt_o,
	output logic irq_o,
	output logic busy_o
);

	bpj_pkg::bpj_state_s s_q, s_d;

	logic wr_acc;
	logic rd_acc;
	logic sys_en;
	logic ls_en;
	logic fall_edge;
	logic link_out;
	logic tick;
	logic [bpj_pkg::IRQ_W-1:0] ev;
	logic [bpj_pkg::CNT_W-1:0] count_inc;

	// ----------------------------------------
	// Combinational helpers
	// ----------------------------------------
	assign wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
	assign rd_acc = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
	assign sys_en = (s_q.sys_div == bpj_pkg::CNT_W'(bpj_pkg::SYS_DIV - 1));
	assign ls_en = (s_q.ls_div == bpj_pkg::CNT_W'(bpj_pkg::LS_DIV - 1));
	// Pin is read only; no direction register exists
	assign fall_edge = s_q.btn_prev & ~s_q.btn_s;
	assign link_out = fall_edge & s_q.link_en[bpj_pkg::CTRL_LINK_EN];
	assign tick = sys_en & s_q.link_en[bpj_pkg::CTRL_TICK_EN]
		& (s_q.tick_cnt == bpj_pkg::CNT_W'(TICK_SYS_CYC - 1));
	assign count_inc = s_q.count + bpj_pkg::CNT_W'(1);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		ev = '0;
		s_d.pslverr = 1'b0;

		// Pin synchroniser; the first stage feeds only the second
		s_d.btn_m = button_input_pin_i;
		s_d.btn_s = s_q.btn_m;
		s_d.btn_prev = s_q.btn_s;

		s_d.sys_div = sys_en ? '0 : s_q.sys_div + bpj_pkg::CNT_W'(1);
		s_d.ls_div = ls_en ? '0 : s_q.ls_div + bpj_pkg::CNT_W'(1);

		// Interval channel: free-running while enabled
		if (!s_q.link_en[bpj_pkg::CTRL_TICK_EN]) begin
			s_d.tick_cnt = '0;
		end else if (sys_en) begin
			s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + bpj_pkg::CNT_W'(1);
		end
		ev[bpj_pkg::IRQ_TICK] = tick;

		// Timer indicator lit (low) while ticks remain
		if (s_q.lit_cnt != '0) begin
			if (tick) begin
				s_d.lit_cnt = s_q.lit_cnt - bpj_pkg::CNT_W'(1);
			end
		end
		s_d.tim_led = (s_d.lit_cnt == '0);

		case (s_q.seq)
			bpj_pkg::SEQ_IDLE: begin
				if (link_out) begin
					s_d.count = bpj_pkg::CNT_RST;
					s_d.thr_lat = s_q.thresh;
					s_d.wait_cnt = '0;
					s_d.act_led = 1'b0;
					ev[bpj_pkg::IRQ_START] = 1'b1;
					s_d.seq = bpj_pkg::SEQ_WAIT;
				end
			end
			bpj_pkg::SEQ_WAIT: begin
				if (ls_en) begin
					if (s_q.wait_cnt == bpj_pkg::CNT_W'(WAIT_LS_CYC - 1)) begin
						s_d.wait_cnt = '0;
						s_d.seq = bpj_pkg::SEQ_SAMPLE;
					end else begin
						s_d.wait_cnt = s_q.wait_cnt + bpj_pkg::CNT_W'(1);
					end
				end
			end
			bpj_pkg::SEQ_SAMPLE: begin
				// Low means pressed
				if (s_q.btn_s) begin
					s_d.long_press = 1'b0;
					ev[bpj_pkg::IRQ_SHORT] = 1'b1;
					s_d.act_led = 1'b1;
					s_d.seq = bpj_pkg::SEQ_IDLE;
				end else begin
					s_d.count = count_inc;
					s_d.seq = bpj_pkg::SEQ_UPDATE;
				end
			end
			bpj_pkg::SEQ_UPDATE: begin
				if (s_q.count < s_q.thr_lat) begin
					s_d.seq = bpj_pkg::SEQ_WAIT;
				end else begin
					s_d.long_press = 1'b1;
					ev[bpj_pkg::IRQ_LONG] = 1'b1;
					s_d.act_led = 1'b1;
					s_d.seq = bpj_pkg::SEQ_IDLE;
				end
			end
			default: begin
				s_d.seq = bpj_pkg::SEQ_IDLE;
			end
		endcase

		// APB writes take effect in the access phase
		if (wr_acc) begin
			if (apb_req_i.paddr == bpj_pkg::OFS_CTRL) begin
				s_d.link_en = apb_req_i.pwdata[2:0];
				if (apb_req_i.pwdata[bpj_pkg::CTRL_TLED_GO]) begin
					s_d.lit_cnt = s_q.lit_ms;
					s_d.tim_led = 1'b0;
				end
				s_d.link_en[bpj_pkg::CTRL_TLED_GO] = 1'b0;
			end else if (apb_req_i.paddr == bpj_pkg::OFS_THRESH) begin
				s_d.thresh = apb_req_i.pwdata[bpj_pkg::CNT_W-1:0];
			end else if (apb_req_i.paddr == bpj_pkg::OFS_IRQ_STAT) begin
				s_d.irq_stat = s_q.irq_stat & ~apb_req_i.pwdata[bpj_pkg::IRQ_W-1:0];
			end else if (apb_req_i.paddr == bpj_pkg::OFS_IRQ_MASK) begin
				s_d.irq_mask = apb_req_i.pwdata[bpj_pkg::IRQ_W-1:0];
			end else if (apb_req_i.paddr == bpj_pkg::OFS_LIT_MS) begin
				s_d.lit_ms = apb_req_i.pwdata[bpj_pkg::CNT_W-1:0];
			end
		end
		// Set wins over a clear in the same cycle
		s_d.irq_stat = s_d.irq_stat | ev;

		// Read data captured in setup, presented in access
		if (rd_acc) begin
			s_d.prdata = '0;
			if (apb_req_i.paddr == bpj_pkg::OFS_CTRL) begin
				s_d.prdata[1:0] = s_q.link_en[1:0];
			end else if (apb_req_i.paddr == bpj_pkg::OFS_THRESH) begin
				s_d.prdata[bpj_pkg::CNT_W-1:0] = s_q.thresh;
			end else if (apb_req_i.paddr == bpj_pkg::OFS_COUNT) begin
				s_d.prdata[bpj_pkg::CNT_W-1:0] = s_q.count;
			end else if (apb_req_i.paddr == bpj_pkg::OFS_STATUS) begin
				s_d.prdata[4:0] = {~s_q.btn_s, s_q.long_press, s_q.tim_led, s_q.act_led,
					s_q.seq != bpj_pkg::SEQ_IDLE};
			end else if (apb_req_i.paddr == bpj_pkg::OFS_IRQ_STAT) begin
				s_d.prdata[bpj_pkg::IRQ_W-1:0] = s_q.irq_stat;
			end else if (apb_req_i.paddr == bpj_pkg::OFS_IRQ_MASK) begin
				s_d.prdata[bpj_pkg::IRQ_W-1:0] = s_q.irq_mask;
			end else if (apb_req_i.paddr == bpj_pkg::OFS_LIT_MS) begin
				s_d.prdata[bpj_pkg::CNT_W-1:0] = s_q.lit_ms;
			end else begin
				s_d.prdata = '0;
			end
		end
		// Error decided in setup for both directions, so it stands in access
		if (apb_req_i.psel && !apb_req_i.penable) begin
			s_d.pslverr = !(apb_req_i.paddr <= bpj_pkg::OFS_LIT_MS
				&& apb_req_i.paddr[1:0] == 2'b00);
		end else if (apb_req_i.psel && apb_req_i.penable) begin
			s_d.pslverr = s_q.pslverr;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.seq <= bpj_pkg::SEQ_IDLE;
			s_q.btn_m <= 1'b1;
			s_q.btn_s <= 1'b1;
			s_q.btn_prev <= 1'b1;
			s_q.thresh <= bpj_pkg::TH_RST;
			s_q.lit_ms <= bpj_pkg::LIT_RST;
			s_q.act_led <= 1'b1;
			s_q.tim_led <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign apb_rsp_o.pready = 1'b1;
	assign apb_rsp_o.pslverr = s_q.pslverr;
	assign apb_rsp_o.prdata = s_q.prdata;
	assign activity_indicator_output_o = s_q.act_led;
	assign timer_indicator_output_o = s_q.tim_led;
	assign sequence_end_interrupt_o = s_q.irq_stat[bpj_pkg::IRQ_LONG];
	assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
	assign busy_o = (s_q.seq != bpj_pkg::SEQ_IDLE);

endmodule

`default_nettype wire

// ---- pkg/bpj_pkg.sv ----
// Package for the button press duration judge: register map, timing, types
package bpj_pkg;

	// ----------------------------------------
	// Clocking and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned SYS_CLK_HZ = 32_000_000;
	localparam int unsigned LS_CLK_HZ = 32_768;
	localparam int unsigned WAIT_MS = 125;
	localparam int unsigned TICK_MS = 1;
	// System clock enable: 250 MHz down to 32 MHz, rounded down
	localparam int unsigned SYS_DIV = CLK_HZ / SYS_CLK_HZ;
	// Low-speed wait clock enable divider
	localparam int unsigned LS_DIV = CLK_HZ / LS_CLK_HZ;
	// Low-speed clock edges per wait step
	localparam int unsigned WAIT_LS_CYC = (LS_CLK_HZ * WAIT_MS + 999) / 1000;
	// System clock edges per millisecond tick
	localparam int unsigned TICK_SYS_CYC = SYS_CLK_HZ / 1000 * TICK_MS;

	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] TH_RST = 16'h0018;
	localparam logic [CNT_W-1:0] LIT_RST = 16'h0064;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_THRESH = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_LIT_MS = 8'h18;

	// Control bits
	localparam int unsigned CTRL_LINK_EN = 0;
	localparam int unsigned CTRL_TICK_EN = 1;
	localparam int unsigned CTRL_TLED_GO = 2;

	// Interrupt status bits
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_LONG = 0;
	localparam int unsigned IRQ_SHORT = 1;
	localparam int unsigned IRQ_TICK = 2;
	localparam int unsigned IRQ_START = 3;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT,
		SEQ_SAMPLE,
		SEQ_UPDATE
	} bpj_seq_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} bpj_apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} bpj_apb_rsp_s;

	typedef struct packed {
		bpj_seq_e seq;
		logic [2:0] link_en;
		logic btn_m;
		logic btn_s;
		logic btn_prev;
		logic [CNT_W-1:0] sys_div;
		logic [CNT_W-1:0] ls_div;
		logic [CNT_W-1:0] wait_cnt;
		logic [CNT_W-1:0] tick_cnt;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] thr_lat;
		logic [CNT_W-1:0] thresh;
		logic [CNT_W-1:0] lit_ms;
		logic [CNT_W-1:0] lit_cnt;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic long_press;
		logic act_led;
		logic tim_led;
		logic [31:0] prdata;
		logic pslverr;
	} bpj_state_s;

endpackage

// ---- test/bpj_judge_monitor.sv ----
// Port checker for the button press duration judge
`timescale 1ns/1ns
`default_nettype none
module bpj_judge_monitor #(
	parameter int unsigned WAIT_LS_CYC = bpj_pkg::WAIT_LS_CYC,
	parameter int unsigned TICK_SYS_CYC = bpj_pkg::TICK_SYS_CYC
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire bpj_pkg::bpj_apb_req_s apb_req_i,
	input wire bpj_pkg::bpj_apb_rsp_s apb_rsp_o,
	input wire logic button_input_pin_i,
	input wire logic activity_indicator_output_o,
	input wire logic timer_indicator_output_o,
	input wire logic sequence_end_interrupt_o,
	input wire logic irq_o,
	input wire logic busy_o
);
	logic acc;
	logic go_wr;
	assign acc = apb_req_i.psel && apb_req_i.penable;
	// Start request for the lit timer, seen in the access phase
	assign go_wr = acc && apb_req_i.pwrite && apb_req_i.paddr == bpj_pkg::OFS_CTRL
		&& apb_req_i.pwdata[bpj_pkg::CTRL_TLED_GO];
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	reset_idle_a: assert property (disable iff (1'b0) srst_i |=>
		activity_indicator_output_o && timer_indicator_output_o && !busy_o && !irq_o
		&& !sequence_end_interrupt_o) else $error("outputs not idle after reset");
	act_busy_a: assert property (busy_o == !activity_indicator_output_o)
		else $error("activity indicator not tied to run");
	// Pin sample to run start: two sync stages, edge compare, state update
	start_fall_a: assert property ($rose(busy_o) |-> !$past(button_input_pin_i, 3))
		else $error("run started without a press");
	run_min_a: assert property ($rose(busy_o) |-> busy_o[*8])
		else $error("run shorter than a wait");
	long_end_a: assert property ($rose(sequence_end_interrupt_o) |-> $fell(busy_o))
		else $error("end interrupt outside run end");
	timer_go_a: assert property ($fell(timer_indicator_output_o) |->
		$past(go_wr) || $past(go_wr, 2)) else $error("timer indicator lit unasked");
	mask_off_a: assert property (acc && apb_req_i.pwrite && apb_req_i.pwdata[3:0] == 4'h0
		&& apb_req_i.paddr == bpj_pkg::OFS_IRQ_MASK |=> !irq_o) else $error("masked irq high");
	bad_addr_a: assert property (acc && (apb_req_i.paddr > bpj_pkg::OFS_LIT_MS
		|| apb_req_i.paddr[1:0] != 2'h0) |-> apb_rsp_o.pslverr) else $error("no slave error");
	ready_a: assert property (acc |-> apb_rsp_o.pready) else $error("access not completed");
endmodule
bind bpj_judge bpj_judge_monitor #(.WAIT_LS_CYC(WAIT_LS_CYC), .TICK_SYS_CYC(TICK_SYS_CYC)) u_mon (
	.clock_i(clock_i), .srst_i(srst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
	.button_input_pin_i(button_input_pin_i),
	.activity_indicator_output_o(activity_indicator_output_o),
	.timer_indicator_output_o(timer_indicator_output_o),
	.sequence_end_interrupt_o(sequence_end_interrupt_o), .irq_o(irq_o), .busy_o(busy_o));
`default_nettype wire

// ---- test/bpj_button_model.sv ----
// Push button on a pulled-up input pin
`timescale 1ns/1ns
`default_nettype none
module bpj_button_model (
	input wire logic clock_i,
	input wire logic press_i,
	output logic pin_o
);
	// Pull-up holds the pin high when released; a press shorts it low
	always_ff @(posedge clock_i) begin
		pin_o <= !press_i;
	end
endmodule
`default_nettype wire

// ---- test/bpj_judge_tb.sv ----
// Self-checking bench for the button press duration judge
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	$display("BAD %s exp %h got %h", n, e, g); n_fail++; end end
module bpj_judge_tb;
	logic clock_i, srst_i, press, pin, act, tim, sev, irq, busy, err;
	bpj_pkg::bpj_apb_req_s req;
	bpj_pkg::bpj_apb_rsp_s rsp;
	int n_fail, check_count, k;
	logic [31:0] rd;
	logic [39:0] rows [7];
	bpj_button_model BTN (.clock_i(clock_i), .press_i(press), .pin_o(pin));
	bpj_judge #(.WAIT_LS_CYC(2), .TICK_SYS_CYC(3)) DUT (.clock_i(clock_i), .srst_i(srst_i),
		.apb_req_i(req), .apb_rsp_o(rsp), .button_input_pin_i(pin),
		.activity_indicator_output_o(act), .timer_indicator_output_o(tim),
		.sequence_end_interrupt_o(sev), .irq_o(irq), .busy_o(busy));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	task test_done;
		$display("Checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Idle edge first, so a release never meets the next setup in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int j;
		@(posedge clock_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clock_i);
		req.penable <= 1'b1;
		j = 0;
		do begin
			@(posedge clock_i);
			j++;
		end while (rsp.pready !== 1'b1 && j < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (j >= 20) begin
			n_fail++;
			test_done();
		end
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("read", e, rd)
	endtask
	task wait_busy(input logic v, input int lim);
		int j;
		for (j = 0; j < lim && busy !== v; j++) @(posedge clock_i);
		if (j >= lim) begin
			n_fail++;
			test_done();
		end
	endtask
	initial begin
		srst_i = 1'b1;
		press = 1'b0;
		req = '0;
		n_fail = 0;
		check_count = 0;
		rows = '{{bpj_pkg::OFS_CTRL, 32'h0}, {bpj_pkg::OFS_THRESH, 32'h18},
			{bpj_pkg::OFS_COUNT, 32'h0}, {bpj_pkg::OFS_IRQ_STAT, 32'h0},
			{bpj_pkg::OFS_IRQ_MASK, 32'h0}, {bpj_pkg::OFS_LIT_MS, 32'h64},
			{bpj_pkg::OFS_STATUS, 32'h6}};
		repeat (3) @(posedge clock_i);
		`CHK("idle", 5'h18, {act, tim, sev, irq, busy})
		srst_i <= 1'b0;
		foreach (rows[i]) rchk(rows[i][39:32], rows[i][31:0]);
		apb(1'b0, 8'h1c, 32'h0);
		`CHK("unmapped", 33'h100000000, {err, rd})
		apb(1'b1, 8'h1d, 32'h0);
		`CHK("write error", 1'b1, err)
		apb(1'b1, bpj_pkg::OFS_COUNT, 32'hffff);
		`CHK("ro write", 1'b0, err)
		apb(1'b1, bpj_pkg::OFS_IRQ_MASK, 32'hf);
		apb(1'b1, bpj_pkg::OFS_THRESH, 32'h2);
		// Link disabled: a press must not start a run
		press <= 1'b1;
		repeat (50) @(posedge clock_i);
		`CHK("no link", 1'b0, busy)
		press <= 1'b0;
		apb(1'b1, bpj_pkg::OFS_CTRL, 32'h1);
		// Long press; threshold changed mid-run must not matter
		press <= 1'b1;
		wait_busy(1'b1, 20);
		`CHK("act lit", 1'b0, act)
		apb(1'b1, bpj_pkg::OFS_THRESH, 32'h10);
		wait_busy(1'b0, 40000);
		`CHK("long", 2'h3, {sev, act})
		rchk(bpj_pkg::OFS_COUNT, 32'h2);
		rchk(bpj_pkg::OFS_IRQ_STAT, 32'h9);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, bpj_pkg::OFS_IRQ_MASK, 32'h0);
		// Mask lands at the access edge; look one cycle later
		@(posedge clock_i);
		`CHK("masked", 1'b0, irq)
		apb(1'b1, bpj_pkg::OFS_IRQ_MASK, 32'hf);
		apb(1'b1, bpj_pkg::OFS_IRQ_STAT, 32'hf);
		rchk(bpj_pkg::OFS_IRQ_STAT, 32'h0);
		press <= 1'b0;
		repeat (20) @(posedge clock_i);
		// Short press: release before the first sample
		press <= 1'b1;
		wait_busy(1'b1, 20);
		repeat (1000) @(posedge clock_i);
		press <= 1'b0;
		wait_busy(1'b0, 40000);
		`CHK("short", 2'h1, {sev, act})
		rchk(bpj_pkg::OFS_IRQ_STAT, 32'ha);
		rchk(bpj_pkg::OFS_COUNT, 32'h0);
		// Timer indicator lit for two interval ticks of 21 clocks
		apb(1'b1, bpj_pkg::OFS_LIT_MS, 32'h2);
		apb(1'b1, bpj_pkg::OFS_CTRL, 32'h7);
		repeat (2) @(posedge clock_i);
		`CHK("tim lit", 1'b0, tim)
		for (k = 0; k < 200 && tim !== 1'b1; k++) @(posedge clock_i);
		`CHK("lit span", 1'b1, k >= 20 && k <= 70)
		apb(1'b0, bpj_pkg::OFS_IRQ_STAT, 32'h0);
		`CHK("tick", 1'b1, rd[bpj_pkg::IRQ_TICK])
		// Reset in mid-run: all back to idle, link off again
		press <= 1'b1;
		wait_busy(1'b1, 20);
		srst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		srst_i <= 1'b0;
		`CHK("mid reset", 5'h18, {act, tim, sev, irq, busy})
		repeat (50) @(posedge clock_i);
		`CHK("link off", 1'b0, busy)
		rchk(bpj_pkg::OFS_CTRL, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
